// ### design/perf_counter_regs.svh
// Constants for the performance monitor: select map, control field layout, reset values.
// Assumes inclusion by bare name from the package and the design modules.
// Overview of operation
// - Even select is control, odd select is counter.
// - Bit 31 read-only flag marks next pair.
// - Presence bit reports at least one pair.
// - Control bits 30:11 read as zero.
// - Six-bit event field; unsupported codes never count.
// - Bit 4 enables request, cleared at reset.
// - Request still gated by status masks, enable.
// - Request merged with hardware interrupt five.
// - Bit 3 enables counting in user mode.
// - Bit 2 supervisor; absent mode reads zero.
// - Bit 1 kernel counting only with both flags clear.
// - Bit 0 counts when exception set, error clear.
// - Never count while error level is set.
// - Counter is read-write, increments per event.
// - Request when counter bit 31 and enable.
// - Counting continues after top bit sets.
// - Pairs extend select numbering in pattern.
`ifndef PERF_COUNTER_REGS_SVH
`define PERF_COUNTER_REGS_SVH
`define PERF_NUM_PAIRS 2
`define PERF_SEL_W 3
`define PERF_EVT_W 6
`define PERF_NUM_EVENTS 8
`define CTL_MORE_BIT 31
`define CTL_EVT_HI 10
`define CTL_EVT_LO 5
`define CTL_IRQ_BIT 4
`define CTL_USER_BIT 3
`define CTL_SUPV_BIT 2
`define CTL_KERN_BIT 1
`define CTL_EXC_BIT 0
`define CTL_WR_MASK 32'h000007ff
`define CTL_RESET 32'h00000000
`define CNT_RESET 32'h00000000
`define SUPV_MODE_PRESENT 1'b1
`endif

// ### design/perf_counter_pkg.sv
// Types shared by the performance monitor modules.
// Assumes the constants header is on the include path.
package perf_counter_pkg;
`include "perf_counter_regs.svh"
    // ----------------------------------------
    // Processor mode as seen by the counters.
    // ----------------------------------------
    typedef enum logic [1:0] {MODE_KERNEL, MODE_SUPV, MODE_USER} proc_mode_e;
    typedef struct packed {
        proc_mode_e mode;
        logic exception_level_flag;
        logic error_level_flag;
    } proc_state_s;
    typedef struct packed {
        logic [`PERF_EVT_W-1:0] event_sel;
        logic irq_en;
        logic user_en;
        logic supv_en;
        logic kern_en;
        logic exc_en;
    } ctl_fields_s;
endpackage : perf_counter_pkg

// ### design/perf_count_qual.sv
// Count qualifier for one counter: picks the event and applies the mode enables.
// Assumes event lines and processor state are synchronous to clk_sys.
`timescale 1ns/1ns
`include "perf_counter_regs.svh"
module perf_count_qual
    import perf_counter_pkg::*;
(
    // Control fields and processor state
    input wire ctl_fields_s ctl,
    input wire proc_state_s pst,
    // Event lines from the pipeline
    input wire logic [`PERF_NUM_EVENTS-1:0] events,
    // Increment request
    output logic count_en
);
    logic evt_hit;
    logic mode_ok;

    // Codes beyond the wired events act as null events.
    always_comb begin
        evt_hit = 1'b0;
        if (ctl.event_sel < `PERF_EVT_W'(`PERF_NUM_EVENTS)) begin
            evt_hit = events[ctl.event_sel[2:0]];
        end
    end

    // Exception and error levels override the nominal mode, since kernel bit is narrower than kernel mode.
    always_comb begin
        mode_ok = 1'b0;
        if (pst.error_level_flag) begin
            mode_ok = 1'b0;
        end else if (pst.exception_level_flag) begin
            mode_ok = ctl.exc_en;
        end else if (pst.mode == MODE_USER) begin
            mode_ok = ctl.user_en;
        end else if (pst.mode == MODE_SUPV) begin
            mode_ok = ctl.supv_en;
        end else begin
            mode_ok = ctl.kern_en;
        end
    end

    assign count_en = evt_hit && mode_ok;
endmodule : perf_count_qual

// ### design/perf_monitor_reg.sv
// Performance counter register block reached by coprocessor-0 moves at register 25.
// Assumes the pipeline gives one-cycle write strobes and samples read data combinationally
// through a registered copy one cycle after the read select is presented.
`timescale 1ns/1ns
`include "perf_counter_regs.svh"
module perf_monitor_reg
    import perf_counter_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Coprocessor register access
    input wire logic cop0_write_instr,
    input wire logic cop0_read_instr,
    input wire logic [`PERF_SEL_W-1:0] sel,
    input wire logic [31:0] wdata,
    // Processor state and events
    input wire proc_state_s pst,
    input wire logic [`PERF_NUM_EVENTS-1:0] events,
    input wire logic hw_int5,
    // Results
    output logic [31:0] rdata_r,
    output logic second_config_pc_r,
    output logic top_irq_pending_bit_r,
    output logic counter_irq_r
);
    ctl_fields_s ctl_r [`PERF_NUM_PAIRS];
    logic [31:0] cnt_r [`PERF_NUM_PAIRS];
    logic [`PERF_NUM_PAIRS-1:0] count_en;
    logic irq_nxt;
    // Width of the stored control fields; the reset word is cut to it on purpose.
    localparam int CTL_W = $bits(ctl_fields_s);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Packs stored fields into the control word, reserved bits zero.
    function automatic logic [31:0] ctl_word(input ctl_fields_s c, input int idx);
        logic [31:0] w;
        w = 32'h00000000;
        w[`CTL_MORE_BIT] = (idx < `PERF_NUM_PAIRS - 1);
        w[`CTL_EVT_HI:`CTL_EVT_LO] = c.event_sel;
        w[`CTL_IRQ_BIT] = c.irq_en;
        w[`CTL_USER_BIT] = c.user_en;
        w[`CTL_SUPV_BIT] = c.supv_en;
        w[`CTL_KERN_BIT] = c.kern_en;
        w[`CTL_EXC_BIT] = c.exc_en;
        return w;
    endfunction : ctl_word

    // ----------------------------------------
    // Counters
    // ----------------------------------------
    for (genvar i = 0; i < `PERF_NUM_PAIRS; i++) begin : g_pair
        perf_count_qual u_qual (
            .ctl(ctl_r[i]),
            .pst(pst),
            .events(events),
            .count_en(count_en[i])
        );

        // Control register at even select; the flag bit is not stored.
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                ctl_r[i] <= ctl_fields_s'(CTL_W'(`CTL_RESET));
            end else if (cop0_write_instr && sel == `PERF_SEL_W'(2 * i)) begin
                ctl_r[i].event_sel <= wdata[`CTL_EVT_HI:`CTL_EVT_LO];
                ctl_r[i].irq_en <= wdata[`CTL_IRQ_BIT];
                ctl_r[i].user_en <= wdata[`CTL_USER_BIT];
                ctl_r[i].supv_en <= wdata[`CTL_SUPV_BIT] & `SUPV_MODE_PRESENT;
                ctl_r[i].kern_en <= wdata[`CTL_KERN_BIT];
                ctl_r[i].exc_en <= wdata[`CTL_EXC_BIT];
            end
        end

        // Counter at odd select; a software write wins over an event in the same cycle.
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                cnt_r[i] <= `CNT_RESET;
            end else if (cop0_write_instr && sel == `PERF_SEL_W'(2 * i + 1)) begin
                cnt_r[i] <= wdata;
            end else if (count_en[i]) begin
                cnt_r[i] <= cnt_r[i] + 32'h00000001;
            end
        end
    end

    // ----------------------------------------
    // Read path and interrupt
    // ----------------------------------------
    // Read data is registered so the output stays a flop; unmapped selects return zero.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 32'h00000000;
        end else if (cop0_read_instr) begin
            rdata_r <= 32'h00000000;
            for (int k = 0; k < `PERF_NUM_PAIRS; k++) begin
                if (sel == `PERF_SEL_W'(2 * k)) begin
                    rdata_r <= ctl_word(ctl_r[k], k);
                end else if (sel == `PERF_SEL_W'(2 * k + 1)) begin
                    rdata_r <= cnt_r[k];
                end
            end
        end
    end

    // Any pair with top bit and enable raises the shared request.
    always_comb begin
        irq_nxt = 1'b0;
        for (int k = 0; k < `PERF_NUM_PAIRS; k++) begin
            irq_nxt = irq_nxt | (cnt_r[k][31] & ctl_r[k].irq_en);
        end
    end

    // Request is only a pending bit; status masks and global enable act downstream.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            counter_irq_r <= 1'b0;
            top_irq_pending_bit_r <= 1'b0;
            second_config_pc_r <= 1'b0;
        end else begin
            counter_irq_r <= irq_nxt;
            top_irq_pending_bit_r <= irq_nxt | hw_int5;
            second_config_pc_r <= (`PERF_NUM_PAIRS > 0);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_NO_COUNT_ERL: assert property (@(posedge clk_sys) disable iff (!rstn)
        pst.error_level_flag && !(cop0_write_instr && sel == 3'h1) |=> $stable(cnt_r[0]))
        else $error("Counter moved at error level.");
    AST_IRQ_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!rstn)
        (cnt_r[0][31] && ctl_r[0].irq_en) |=> counter_irq_r)
        else $error("Missing counter request.");
    AST_IRQ_OFF: assert property (@(posedge clk_sys) disable iff (!rstn)
        !(cnt_r[0][31] && ctl_r[0].irq_en) && !(cnt_r[1][31] && ctl_r[1].irq_en) |=> !counter_irq_r)
        else $error("Spurious counter request.");
    AST_PENDING: assert property (@(posedge clk_sys) disable iff (!rstn)
        counter_irq_r |-> top_irq_pending_bit_r)
        else $error("Pending bit missing.");
    AST_INCR: assert property (@(posedge clk_sys) disable iff (!rstn)
        count_en[0] && !cop0_write_instr |=> cnt_r[0] == $past(cnt_r[0]) + 32'h00000001)
        else $error("Counter did not step.");
    AST_RSVD: assert property (@(posedge clk_sys) disable iff (!rstn)
        cop0_read_instr && sel == 3'h0 |=> rdata_r[30:11] == 20'h00000)
        else $error("Reserved bits not zero.");
    AST_MORE: assert property (@(posedge clk_sys) disable iff (!rstn)
        cop0_read_instr && sel == 3'h0 |=> rdata_r[31])
        else $error("More flag wrong on first pair.");
    AST_LAST: assert property (@(posedge clk_sys) disable iff (!rstn)
        cop0_read_instr && sel == 3'h2 |=> !rdata_r[31])
        else $error("More flag set on last pair.");
    AST_PC: assert property (@(posedge clk_sys) disable iff (!rstn)
        $past(rstn) |-> second_config_pc_r)
        else $error("Presence bit clear.");
    AST_PEND_HW: assert property (@(posedge clk_sys) disable iff (!rstn)
        hw_int5 |=> top_irq_pending_bit_r)
        else $error("Hardware interrupt five not merged.");

    // Mode gating on pair 0, error level on both pairs; each mode or exception-level gate check clears only the enable that should matter.
    AST_USER_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
        pst.mode == MODE_USER && !pst.exception_level_flag && !pst.error_level_flag && !ctl_r[0].user_en
        |-> !count_en[0])
        else $error("Counted in user mode while disabled.");
    AST_SUPV_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
        pst.mode == MODE_SUPV && !pst.exception_level_flag && !pst.error_level_flag && !ctl_r[0].supv_en
        |-> !count_en[0])
        else $error("Counted in supervisor mode while disabled.");
    AST_KERN_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
        pst.mode == MODE_KERNEL && !pst.exception_level_flag && !pst.error_level_flag && !ctl_r[0].kern_en
        |-> !count_en[0])
        else $error("Counted in kernel mode while disabled.");
    AST_EXL_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
        pst.exception_level_flag && !pst.error_level_flag && !ctl_r[0].exc_en |-> !count_en[0])
        else $error("Counted at exception level while disabled.");
    AST_ERL_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
        pst.error_level_flag |-> !(|count_en))
        else $error("Count enable raised at error level.");
    AST_USER_ON: assert property (@(posedge clk_sys) disable iff (!rstn)
        pst.mode == MODE_USER && !pst.exception_level_flag && !pst.error_level_flag && ctl_r[0].user_en
        && ctl_r[0].event_sel < 6'h08 && events[ctl_r[0].event_sel[2:0]] |-> count_en[0])
        else $error("Enabled event not counted.");
    AST_NULL_EVT: assert property (@(posedge clk_sys) disable iff (!rstn)
        ctl_r[0].event_sel >= 6'h08 |-> !count_en[0])
        else $error("Unsupported event code counted.");

    // Counter datapath and select map.
    AST_WR_CNT: assert property (@(posedge clk_sys) disable iff (!rstn)
        cop0_write_instr && sel == 3'h1 |=> cnt_r[0] == $past(wdata))
        else $error("Counter write lost.");
    AST_CNT1_WR: assert property (@(posedge clk_sys) disable iff (!rstn)
        cop0_write_instr && sel == 3'h3 |=> cnt_r[1] == $past(wdata))
        else $error("Second counter write lost.");
    AST_HOLD_IDLE: assert property (@(posedge clk_sys) disable iff (!rstn)
        !count_en[0] && !(cop0_write_instr && sel == 3'h1) |=> $stable(cnt_r[0]))
        else $error("Counter moved without an event.");
    AST_KEEP_COUNT: assert property (@(posedge clk_sys) disable iff (!rstn)
        cnt_r[0][31] && count_en[0] && !cop0_write_instr |=> cnt_r[0] == $past(cnt_r[0]) + 32'h00000001)
        else $error("Counting stopped after top bit set.");
    AST_WRAP: assert property (@(posedge clk_sys) disable iff (!rstn)
        count_en[1] && !cop0_write_instr && cnt_r[1] == 32'hffffffff |=> cnt_r[1] == 32'h00000000)
        else $error("Counter did not wrap to zero.");
    AST_CTL_WR: assert property (@(posedge clk_sys) disable iff (!rstn)
        cop0_write_instr && sel == 3'h2 |=> ctl_r[1].irq_en == $past(wdata[`CTL_IRQ_BIT]))
        else $error("Second control write lost.");
    AST_RD_CNT: assert property (@(posedge clk_sys) disable iff (!rstn)
        cop0_read_instr && sel == 3'h1 |=> rdata_r == $past(cnt_r[0]))
        else $error("Counter read returned wrong word.");
    AST_UNMAPPED: assert property (@(posedge clk_sys) disable iff (!rstn)
        cop0_read_instr && sel > 3'h3 |=> rdata_r == 32'h00000000)
        else $error("Unmapped select read not zero.");

    // ----------------------------------------
    // Coverage
    // ----------------------------------------
    // Main scenarios: wrap, request, control write, null event, error level.
    COV_WRAP: cover property (@(posedge clk_sys) disable iff (!rstn)
        cnt_r[1] == 32'hffffffff && count_en[1] ##1 cnt_r[1] == 32'h00000000);
    COV_IRQ: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(counter_irq_r));
    COV_CTL_WR: cover property (@(posedge clk_sys) disable iff (!rstn) cop0_write_instr && sel == 3'h2);
    COV_NULL_EVT: cover property (@(posedge clk_sys) disable iff (!rstn) ctl_r[0].event_sel >= 6'h08 && events != 8'h00);
    COV_ERL_EVT: cover property (@(posedge clk_sys) disable iff (!rstn) pst.error_level_flag && events != 8'h00);
endmodule : perf_monitor_reg

// ### tb/pipe_model.sv
// Pipeline stand-in: processor state and bursts on one event line.
// Assumes the bench drives its requests on rising edges of clk_sys.
`timescale 1ns/1ns
module pipe_model
    import perf_counter_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Requests from the bench
    input wire logic go,
    input wire logic [2:0] line,
    input wire logic [7:0] n,
    input wire proc_state_s st,
    // Toward the block
    output proc_state_s pst,
    output logic [7:0] events
);
    logic [7:0] left_r;
    // Burst length and mode both move on the clock, as a real pipeline would.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            left_r <= 8'h00;
            pst <= '0;
        end else begin
            left_r <= go ? n : left_r - 8'(left_r != 8'h00);
            pst <= st;
        end
    end
    // Idle lines stay low so no stray count can sneak in.
    assign events = (left_r != 8'h00) ? (8'h01 << line) : 8'h00;
endmodule : pipe_model

// ### tb/perf_monitor_reg_bench.sv
// Self-checking bench for the performance monitor register block.
// Assumes pipe_model supplies the events and the processor state.
`timescale 1ns/1ns
module perf_monitor_reg_bench
    import perf_counter_pkg::*;
;
    logic clk_sys, rstn, wr, rd, go, hw_int5, pc_r, pend_r, irq_r;
    logic [2:0] sel, line;
    logic [7:0] n, events;
    logic [31:0] wdata, rdata_r;
    proc_state_s st, pst;
    int error_cnt, n_compared;
    perf_monitor_reg dut (.clk_sys(clk_sys), .rstn(rstn), .cop0_write_instr(wr), .cop0_read_instr(rd),
        .sel(sel), .wdata(wdata), .pst(pst), .events(events), .hw_int5(hw_int5), .rdata_r(rdata_r),
        .second_config_pc_r(pc_r), .top_irq_pending_bit_r(pend_r), .counter_irq_r(irq_r));
    pipe_model pm (.clk_sys(clk_sys), .rstn(rstn), .go(go), .line(line), .n(n), .st(st), .pst(pst),
        .events(events));
    // Clock.
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // --------------------------------
    // Helpers
    // --------------------------------
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    task automatic wreg(input logic [2:0] s, input logic [31:0] d);
        @(posedge clk_sys);
        wr <= 1'b1;
        sel <= s;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wreg
    // Read data lands on the same edge that takes the strobe.
    task automatic rreg(input logic [2:0] s, input logic [31:0] exp);
        @(posedge clk_sys);
        rd <= 1'b1;
        sel <= s;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 chk(exp, rdata_r);
    endtask : rreg
    task automatic fire(input logic [2:0] k, input logic [7:0] cnt);
        @(posedge clk_sys);
        go <= 1'b1;
        line <= k;
        n <= cnt;
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (cnt + 3) @(posedge clk_sys);
        #1;
    endtask : fire
    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic t_regs;
        rreg(3'h0, 32'h80000000);
        chk(32'h1, {31'h0, pc_r});
        rreg(3'h2, 32'h0);
        wreg(3'h0, 32'hffffffff);
        rreg(3'h0, 32'h800007ff);
        wreg(3'h5, 32'h12345678);
        rreg(3'h5, 32'h0);
        wreg(3'h3, 32'ha5a5a5a5);
        rreg(3'h3, 32'ha5a5a5a5);
        rreg(3'h1, 32'h0);
    endtask : t_regs
    // User, supervisor, kernel and exception level each count only under their own enable; error level and the wrong line never count.
    task automatic t_modes;
        logic [31:0] en;
        for (int i = 0; i < 5; i++) begin
            en = (i < 4) ? (32'h1 << (3 - i)) : 32'h0;
            @(posedge clk_sys);
            st <= '{(i == 0) ? MODE_USER : (i == 1) ? MODE_SUPV : MODE_KERNEL, i >= 3, i == 4};
            wreg(3'h1, 32'h0);
            wreg(3'h0, 32'h40 | (32'h0f & ~en));
            fire(3'h2, 8'h03);
            rreg(3'h1, 32'h0);
            wreg(3'h0, (i == 4) ? 32'h4f : (32'h40 | en));
            fire(3'h3, 8'h02);
            fire(3'h2, 8'h03);
            rreg(3'h1, (i == 4) ? 32'h0 : 32'h3);
        end
        @(posedge clk_sys);
        st <= '{MODE_USER, 1'b0, 1'b0};
        wreg(3'h0, 32'h128);
        fire(3'h1, 8'h02);
        rreg(3'h1, 32'h0);
    endtask : t_modes
    task automatic t_irq;
        wreg(3'h1, 32'h7ffffffe);
        wreg(3'h0, 32'h58);
        fire(3'h2, 8'h01);
        chk(32'h0, {31'h0, irq_r});
        fire(3'h2, 8'h01);
        chk(32'h1, {31'h0, irq_r});
        chk(32'h1, {31'h0, pend_r});
        fire(3'h2, 8'h02);
        rreg(3'h1, 32'h80000002);
        wreg(3'h0, 32'h48);
        fire(3'h2, 8'h01);
        chk(32'h0, {31'h0, pend_r});
        @(posedge clk_sys);
        hw_int5 <= 1'b1;
        fire(3'h2, 8'h00);
        chk(32'h1, {31'h0, pend_r});
        @(posedge clk_sys);
        hw_int5 <= 1'b0;
        wreg(3'h3, 32'hffffffff);
        wreg(3'h2, 32'h48);
        fire(3'h2, 8'h01);
        rreg(3'h3, 32'h0);
    endtask : t_irq
    task automatic end_sim;
        $display("compared=%0d mismatches=%0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    // Main sequence.
    initial begin
        {rstn, wr, rd, go, hw_int5, sel, line, n, wdata, st} = '0;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        t_regs;
        $display("regs done");
        t_modes;
        $display("modes done");
        t_irq;
        $display("irq done");
        end_sim;
    end
    // The tests need well under 2000 cycles; ten times that means a hang.
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        end_sim;
    end
endmodule : perf_monitor_reg_bench
